// File: hdl/cic_rate_change_filter_consts.svh
// Purpose: Constants for the CIC rate change filter
// Assumes: Included by the package and the filter module
// Notes:   Defaults, range limits and type codes; the top module parameters override the defaults
`ifndef CIC_RATE_CHANGE_FILTER_CONSTS_SVH
`define CIC_RATE_CHANGE_FILTER_CONSTS_SVH
`define CIC_IN_WIDTH_DEF     16
`define CIC_IN_WIDTH_MIN     1
`define CIC_IN_WIDTH_MAX     128
`define CIC_IN_BINPT_DEF     0
`define CIC_RATE_DEF         8
`define CIC_RATE_MIN         8
`define CIC_RATE_MAX         16384
`define CIC_STAGES_DEF       3
`define CIC_STAGES_MIN       1
`define CIC_STAGES_MAX       32
`define CIC_DIFF_DELAY_DEF   1
`define CIC_DIFF_DELAY_MIN   1
`define CIC_DIFF_DELAY_MAX   4
`define CIC_PIPE_COMB_DEF    1
`define CIC_TYPE_DECIMATE    1'b0
`define CIC_TYPE_INTERPOLATE 1'b1
`endif

// File: hdl/cic_rate_change_filter_pkg.sv
// Purpose: Types for the CIC rate change filter
// Assumes: Constants come from the consts header
// Notes:   Filter type selects the structure at build time
`include "cic_rate_change_filter_consts.svh"
package cic_rate_change_filter_pkg;
  typedef enum logic [0:0] {
    filt_decimate    = `CIC_TYPE_DECIMATE,
    filt_interpolate = `CIC_TYPE_INTERPOLATE
  } filter_type_t;
endpackage

// File: hdl/cic_rate_change_filter.sv
// Purpose: Cascaded integrator-comb decimator or interpolator
// Assumes: One clock; input valid strobe marks each input sample
// Notes:   Output width carries full growth; binary point stays at IN_BINPT
`include "cic_rate_change_filter_consts.svh"
module cic_rate_change_filter
  import cic_rate_change_filter_pkg::*;
#(
  parameter int           IN_WIDTH   = `CIC_IN_WIDTH_DEF,
  parameter int           IN_BINPT   = `CIC_IN_BINPT_DEF,
  parameter int           RATE       = `CIC_RATE_DEF,
  parameter int           STAGES     = `CIC_STAGES_DEF,
  parameter int           DIFF_DELAY = `CIC_DIFF_DELAY_DEF,
  parameter bit           PIPE_COMB  = `CIC_PIPE_COMB_DEF,
  parameter filter_type_t FILT_TYPE  = filt_decimate,
  // Full-precision width, input plus growth
  parameter int           ACC_WIDTH  =
    IN_WIDTH + STAGES * $clog2(RATE * DIFF_DELAY)
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // Sample input
  input  wire logic signed [IN_WIDTH-1:0]  sample_input,
  input  wire logic                        sample_valid,
  // Filtered output
  output logic signed [ACC_WIDTH-1:0]      filtered_output,
  output logic                             filtered_valid
);

  // ----------------------------------------------------------------
  // Build-time checks
  // ----------------------------------------------------------------
  localparam int DLY = (FILT_TYPE == filt_decimate) ? DIFF_DELAY
                                                   : DIFF_DELAY;
  localparam int CW  = $clog2(RATE);

  if (IN_WIDTH < `CIC_IN_WIDTH_MIN || IN_WIDTH > `CIC_IN_WIDTH_MAX)
    $error("Input width out of range");
  if (RATE < `CIC_RATE_MIN || RATE > `CIC_RATE_MAX)
    $error("Rate change factor out of range");
  if (STAGES < `CIC_STAGES_MIN || STAGES > `CIC_STAGES_MAX)
    $error("Stage count out of range");
  if (DIFF_DELAY < `CIC_DIFF_DELAY_MIN || DIFF_DELAY > `CIC_DIFF_DELAY_MAX)
    $error("Differential delay out of range");
  if (IN_BINPT < 0 || IN_BINPT > IN_WIDTH)
    $error("Binary point out of range");

  // ----------------------------------------------------------------
  // Rate counter
  // ----------------------------------------------------------------
  logic [CW-1:0] phase_ff;
  logic          busy_ff;     // Interpolator emitting a burst
  wire logic     phase_last = (phase_ff == CW'(RATE - 1));
  wire logic     dec_step   = sample_valid;
  wire logic     int_step   = busy_ff;
  wire logic     step       = (FILT_TYPE == filt_decimate) ? dec_step
                                                          : int_step;
  wire logic [CW-1:0] nxt_phase = phase_last ? '0 : phase_ff + 1'b1;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_ff <= '0;
      busy_ff  <= 1'b0;
    end else begin
      if (FILT_TYPE == filt_interpolate && sample_valid)
        busy_ff <= 1'b1;
      else if (step && phase_last)
        busy_ff <= 1'b0;
      if (FILT_TYPE == filt_interpolate && sample_valid)
        phase_ff <= '0;
      else if (step)
        phase_ff <= nxt_phase;
    end
  end

  // ----------------------------------------------------------------
  // Integrator and comb chains
  // ----------------------------------------------------------------
  logic signed [ACC_WIDTH-1:0] integ_ff [STAGES];
  logic signed [ACC_WIDTH-1:0] comb_in  [STAGES+1];
  logic                        comb_vld [STAGES+1];
  logic signed [ACC_WIDTH-1:0] integ_in;
  logic signed [ACC_WIDTH-1:0] down_ff;
  logic                        down_vld_ff;

  // Decimator: input feeds integrators; interpolator: input feeds combs, zero-stuffed into integrators
  wire logic signed [ACC_WIDTH-1:0] ext_in = ACC_WIDTH'(sample_input);
  wire logic signed [ACC_WIDTH-1:0] comb_last = comb_in[STAGES];
  logic signed [ACC_WIDTH-1:0] up_hold_ff;
  // Zero-stuffing: comb result on phase 0, zeros otherwise
  wire logic signed [ACC_WIDTH-1:0] up_sample =
    (phase_ff == '0) ? up_hold_ff : '0;

  assign integ_in   = (FILT_TYPE == filt_decimate) ? ext_in : up_sample;
  assign comb_in[0] = (FILT_TYPE == filt_decimate) ? down_ff : ext_in;
  assign comb_vld[0] = (FILT_TYPE == filt_decimate) ? down_vld_ff
                                                   : sample_valid;

  // Integrator runs at the high rate
  genvar i;
  for (i = 0; i < STAGES; i++) begin : g_integ
    wire logic signed [ACC_WIDTH-1:0] src =
      (i == 0) ? integ_in : integ_ff[(i == 0) ? 0 : i-1];
    always_ff @(posedge clock or posedge rst) begin
      if (rst)
        integ_ff[i] <= '0;
      else if (step)
        integ_ff[i] <= integ_ff[i] + src;
    end
  end

  // Down-sampler keeps one of every R last-integrator outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      down_ff     <= '0;
      down_vld_ff <= 1'b0;
    end else begin
      down_vld_ff <= dec_step && phase_last;
      if (dec_step && phase_last)
        down_ff <= integ_ff[STAGES-1];
    end
  end

  // Combs run at the low rate; delay R*M high-rate samples is M low-rate
  for (i = 0; i < STAGES; i++) begin : g_comb
    logic signed [ACC_WIDTH-1:0] dly_ff [DLY];
    logic signed [ACC_WIDTH-1:0] res_ff;
    logic                        vld_ff;
    wire logic signed [ACC_WIDTH-1:0] diff = comb_in[i] - dly_ff[DLY-1];
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        for (int k = 0; k < DLY; k++)
          dly_ff[k] <= '0;
        res_ff <= '0;
        vld_ff <= 1'b0;
      end else begin
        vld_ff <= comb_vld[i];
        if (comb_vld[i]) begin
          dly_ff[0] <= comb_in[i];
          for (int k = 1; k < DLY; k++)
            dly_ff[k] <= dly_ff[k-1];
          res_ff <= diff;
        end
      end
    end
    // Pipelined or combinational comb output
    assign comb_in[i+1]  = PIPE_COMB ? res_ff : diff;
    assign comb_vld[i+1] = PIPE_COMB ? vld_ff : comb_vld[i];
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      up_hold_ff      <= '0;
      filtered_output <= '0;
      filtered_valid  <= 1'b0;
    end else begin
      if (comb_vld[STAGES])
        up_hold_ff <= comb_last;
      if (FILT_TYPE == filt_decimate) begin
        filtered_valid <= comb_vld[STAGES];
        if (comb_vld[STAGES])
          filtered_output <= comb_last;
      end else begin
        filtered_valid <= step;
        if (step)
          filtered_output <= integ_ff[STAGES-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic valid_prev_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) valid_prev_ff <= 1'b0;
    else     valid_prev_ff <= sample_valid;
  end

  AST_DOWN_STROBE: assert property (@(posedge clock)
    disable iff (rst)
    (FILT_TYPE == filt_decimate && sample_valid && phase_last)
      |=> down_vld_ff)
    else $error("Down-sampler missed its strobe");
  AST_DOWN_ONLY: assert property (@(posedge clock)
    disable iff (rst)
    down_vld_ff |-> $past(phase_last) && $past(dec_step))
    else $error("Down-sampler fired off phase");
  AST_INTEG_SUM: assert property (@(posedge clock)
    disable iff (rst)
    step |=> integ_ff[0] == $past(integ_ff[0]) + $past(integ_in))
    else $error("Integrator sum wrong");
  AST_INTEG_HOLD: assert property (@(posedge clock)
    disable iff (rst)
    !step |=> $stable(integ_ff[0]))
    else $error("Integrator moved without a step");
  AST_COMB_FIRST: assert property (@(posedge clock)
    disable iff (rst)
    comb_vld[0] |=> g_comb[0].dly_ff[0] == $past(comb_in[0]))
    else $error("Comb delay line not loaded");
  AST_ZERO_STUFF: assert property (@(posedge clock)
    disable iff (rst)
    (FILT_TYPE == filt_interpolate && phase_ff != '0) |-> integ_in == '0)
    else $error("Nonzero sample stuffed");
  AST_PHASE_RANGE: assert property (@(posedge clock)
    disable iff (rst)
    phase_ff <= CW'(RATE - 1))
    else $error("Phase counter past rate");
  AST_OUT_VALID: assert property (@(posedge clock)
    disable iff (rst)
    (FILT_TYPE == filt_decimate && comb_vld[STAGES]) |=> filtered_valid)
    else $error("Output valid missing");

  COV_DOWN: cover property (@(posedge clock) disable iff (rst) down_vld_ff);
  COV_OUT: cover property (@(posedge clock) disable iff (rst)
    filtered_valid);
  COV_BACK: cover property (@(posedge clock) disable iff (rst)
    valid_prev_ff && sample_valid);
  COV_BURST: cover property (@(posedge clock) disable iff (rst)
    busy_ff && phase_last);

endmodule

// File: tb/cic_stream_sink.sv
// Purpose: Downstream sink that takes filtered samples
// Assumes: Output strobe is a one-cycle pulse per sample
// Notes:   Keeps the last sample taken and a running count
module cic_stream_sink #(
  parameter int AW = 25
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Filtered stream
  input  wire logic signed [AW-1:0] filtered_output,
  input  wire logic                 filtered_valid,
  // Observed values
  output logic signed [AW-1:0]      last_value,
  output int                        n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_value <= '0;
      n_out      <= 0;
    end else if (filtered_valid) begin
      last_value <= filtered_output;
      n_out      <= n_out + 1;
    end
  end
endmodule

// File: tb/tb_cic_rate_change_filter.sv
// Purpose: Self-checking bench for the decimating and interpolating filter
// Assumes: Rate 8, three stages, delay 1; decimator piped, interpolator not
// Notes:   DC gain (R*M)**N decimating, (R*M)**N/R interpolating
module tb_cic_rate_change_filter;
  import cic_rate_change_filter_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W  = 16;
  localparam int R  = 8;
  localparam int N  = 3;
  localparam int AW = W + N * $clog2(R);
  logic                 clock;
  logic                 rst;
  logic signed [W-1:0]  sample_input;
  logic                 sample_valid;
  logic signed [AW-1:0] filtered_output;
  logic                 filtered_valid;
  logic signed [AW-1:0] last_value;
  int                   n_out;
  int                   n_fail;
  int                   n_tests;
  logic signed [W-1:0]  up_input;
  logic                 up_valid;
  logic signed [AW-1:0] up_output;
  logic                 up_out_valid;
  logic signed [AW-1:0] up_last;
  int                   up_n_out;

  cic_rate_change_filter #(.IN_WIDTH(W), .RATE(R), .STAGES(N),
    .DIFF_DELAY(1), .PIPE_COMB(1'b1), .FILT_TYPE(filt_decimate)) i_dut (
    .clock(clock), .rst(rst), .sample_input(sample_input),
    .sample_valid(sample_valid), .filtered_output(filtered_output),
    .filtered_valid(filtered_valid));
  cic_stream_sink #(.AW(AW)) i_sink (
    .clock(clock), .rst(rst), .filtered_output(filtered_output),
    .filtered_valid(filtered_valid), .last_value(last_value),
    .n_out(n_out));
  cic_rate_change_filter #(.IN_WIDTH(W), .RATE(R), .STAGES(N),
    .DIFF_DELAY(1), .PIPE_COMB(1'b0), .FILT_TYPE(filt_interpolate))
    i_dut_up (
    .clock(clock), .rst(rst), .sample_input(up_input),
    .sample_valid(up_valid), .filtered_output(up_output),
    .filtered_valid(up_out_valid));
  cic_stream_sink #(.AW(AW)) i_sink_up (
    .clock(clock), .rst(rst), .filtered_output(up_output),
    .filtered_valid(up_out_valid), .last_value(up_last),
    .n_out(up_n_out));

  // ----------------------------------------
  // Clock
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [AW-1:0] got, input logic [AW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("n_tests %0d n_fail %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic feed(input logic signed [W-1:0] x, input int cnt,
                      input int gap);
    repeat (cnt) begin
      @(posedge clock) begin
        sample_input <= x;
        sample_valid <= 1'b1;
      end
      @(posedge clock) sample_valid <= 1'b0;
      repeat (gap) @(posedge clock);
    end
  endtask

  task automatic feed_up(input logic signed [W-1:0] x, input int cnt);
    repeat (cnt) begin
      @(posedge clock) begin
        up_input <= x;
        up_valid <= 1'b1;
      end
      @(posedge clock) up_valid <= 1'b0;
      repeat (R - 2) @(posedge clock);
    end
  endtask

  task automatic wait_out(input int target, input bit up);
    int i;
    for (i = 0; i < 40 && (up ? up_n_out : n_out) < target; i++)
      @(posedge clock);
    if ((up ? up_n_out : n_out) < target) begin
      n_fail++;
      give_verdict();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    check(filtered_output, '0);
    check(AW'(filtered_valid), '0);
    check(up_output, '0);
  endtask

  task automatic test_dc(input logic signed [W-1:0] x);
    int n0;
    logic signed [AW-1:0] exp;
    n0  = n_out;
    exp = AW'(x) * AW'(R ** N);
    feed(x, 10 * R, 0);
    wait_out(n0 + 10, 1'b0);
    check(last_value, exp);
  endtask

  task automatic test_rate();
    int n0;
    n0 = n_out;
    feed(16'sh0001, 2 * R, 3);
    wait_out(n0 + 2, 1'b0);
    repeat (40) @(posedge clock);
    check(AW'(n_out), AW'(n0 + 2));
  endtask

  task automatic test_up(input logic signed [W-1:0] x);
    int n0;
    logic signed [AW-1:0] exp;
    n0  = up_n_out;
    exp = AW'(x) * AW'(R ** (N - 1));
    feed_up(x, 10);
    wait_out(n0 + 10 * R, 1'b1);
    repeat (4) @(posedge clock);
    check(AW'(up_n_out - n0), AW'(10 * R));
    check(up_last, exp);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n_fail       = 0;
    n_tests      = 0;
    rst          = 1'b1;
    sample_input = '0;
    sample_valid = 1'b0;
    up_input     = '0;
    up_valid     = 1'b0;
    repeat (5) @(posedge clock);
    #1 test_reset();
    @(posedge clock) rst <= 1'b0;
    test_dc(16'sh0001);
    test_dc(-16'sh0003);
    test_dc(16'sh7fff);
    test_dc(-16'sh8000);
    test_rate();
    test_up(16'sh0005);
    test_up(-16'sh0100);
    give_verdict();
  end
endmodule
